// ---- hspcb_pkg.sv ----
package hspcb_pkg;
    // Command codes
    localparam logic [7:0] CMD_SWITCH_CTRL   = 8'h01;
    localparam logic [7:0] CMD_FAULT_CLEAR   = 8'h03;
    localparam logic [7:0] CMD_LAST_CLEAR    = 8'h08;
    localparam logic [7:0] CMD_LAST_RESTORE  = 8'h0C;
    localparam logic [7:0] CMD_POWER_CYCLE   = 8'h0F;
    localparam logic [7:0] CMD_WRITE_GUARD   = 8'h10;
    localparam logic [7:0] CMD_STORE_ALL     = 8'h15;
    localparam logic [7:0] CMD_RESTORE_ALL   = 8'h16;
    localparam logic [7:0] CMD_FEATURE       = 8'h19;
    localparam logic [7:0] CMD_DIV_RATIO     = 8'h29;
    localparam logic [7:0] CMD_RISE_THRESH   = 8'h35;
    localparam logic [7:0] CMD_PAGE          = 8'h00;
    // Reset values
    localparam logic [7:0]  RST_SWITCH_CTRL  = 8'h80;
    localparam logic [7:0]  RST_WRITE_GUARD  = 8'h00;
    localparam logic [7:0]  FEATURE_VALUE    = 8'hD0;
    localparam logic [15:0] RST_DIV_RATIO    = 16'h0140;
    localparam logic [15:0] RST_RISE_THRESH  = 16'h0023;
    // Field layouts
    localparam int SWITCH_ON_BIT             = 7;
    localparam logic [7:0]  SWITCH_MASK      = 8'h80;
    localparam logic [15:0] DIV_RATIO_MASK   = 16'h07FF;
    localparam logic [15:0] RISE_THRESH_MASK = 16'h007F;
    localparam int EXT_CLR_LAST_BIT          = 6;
    localparam int EXT_SKIP_REC_BIT          = 3;
    localparam int EFCFG_FINE_BIT            = 6;
    localparam int VPROT_HALF_BIT            = 7;
    // Write-guard levels
    localparam logic [7:0] GUARD_OPEN        = 8'h00;
    localparam logic [7:0] GUARD_CTRL_MASK   = 8'hDF;
    localparam logic [7:0] GUARD_CTRL        = 8'h40;
    localparam logic [7:0] GUARD_LOCKED      = 8'h80;
    // Resolutions in mV
    localparam logic [9:0] RES_COARSE_MV     = 10'h1F4;
    localparam logic [9:0] RES_MID_MV        = 10'h0FA;
    localparam logic [9:0] RES_FINE_MV       = 10'h07D;
    // Power-cycle off time
    localparam int  CLK_MHZ                  = 200;
    localparam real CYCLE_OFF_S              = 5.0;
    localparam longint CYCLE_OFF_CYC         = longint'(CYCLE_OFF_S * 1.0E6) * CLK_MHZ;

    typedef enum logic [1:0] {
        HSPCB_ON_S  = 2'b00,
        HSPCB_OFF_S = 2'b01,
        HSPCB_CYC_S = 2'b10
    } hspcb_pwr_e;

    typedef struct packed {
        logic clear_status;
        logic clear_last_nvm;
        logic clear_last_reg;
        logic restore_last;
        logic store_all;
        logic store_rec;
        logic restore_all;
    } hspcb_evt_s;
endpackage : hspcb_pkg

// ---- hspcb_bank.sv ----
module hspcb_bank
    import hspcb_pkg::*;
#(
    parameter longint OFF_CYCLES = CYCLE_OFF_CYC
)(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESET_I,
    input  wire logic        WR_STB_I,
    input  wire logic        SEND_STB_I,
    input  wire logic [7:0]  CMD_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic [7:0]  RD_CMD_I,
    input  wire logic        FAULT_SHUTDOWN_I,
    input  wire logic        EXT_CLR_LAST_I,
    input  wire logic        EXT_SKIP_REC_I,
    input  wire logic        EFCFG_FINE_I,
    input  wire logic        VPROT_HALF_I,
    input  wire logic [15:0] NVM_DIV_RATIO_I,
    input  wire logic [15:0] NVM_RISE_THRESH_I,
    input  wire logic [7:0]  NVM_SWITCH_CTRL_I,
    output logic [15:0]      RDATA_O,
    output logic             RD_HIT_O,
    output logic             WR_REJECT_O,
    output logic             FET_ON_O,
    output hspcb_evt_s       EVT_O,
    output logic [6:0]       RISE_CODE_O,
    output logic [9:0]       RES_MV_O
);
    function automatic logic allowed(input logic [7:0] g, input logic [7:0] c);
        if (g == GUARD_OPEN)
            return 1'b1;
        if ((g & GUARD_CTRL_MASK) == GUARD_CTRL)
            return (c == CMD_PAGE) || (c == CMD_SWITCH_CTRL) || (c == CMD_WRITE_GUARD);
        return c == CMD_WRITE_GUARD;
    endfunction : allowed

    function automatic logic guard_legal(input logic [7:0] v);
        return (v == GUARD_OPEN) || ((v & GUARD_CTRL_MASK) == GUARD_CTRL) || (v == GUARD_LOCKED);
    endfunction : guard_legal

    logic [7:0]  switch_r, switch_nxt;
    logic [7:0]  guard_r, guard_nxt;
    logic [15:0] ratio_r, ratio_nxt;
    logic [15:0] rise_r, rise_nxt;
    hspcb_pwr_e  pwr_r, pwr_nxt;
    logic [39:0] cyc_r, cyc_nxt;
    hspcb_evt_s  evt_r, evt_nxt;
    logic        rej_r, rej_nxt;
    logic        ok;

    always_comb
    begin
        ok         = allowed(guard_r, CMD_I);
        switch_nxt = switch_r;
        guard_nxt  = guard_r;
        ratio_nxt  = ratio_r;
        rise_nxt   = rise_r;
        pwr_nxt    = pwr_r;
        cyc_nxt    = cyc_r;
        evt_nxt    = '0;
        rej_nxt    = 1'b0;
        if (pwr_r == HSPCB_CYC_S)
        begin
            if (cyc_r == 40'h0)
                pwr_nxt = HSPCB_ON_S;
            else
                cyc_nxt = cyc_r - 40'h1;
        end
        if ((WR_STB_I || SEND_STB_I) && !ok)
            rej_nxt = 1'b1;
        else if (WR_STB_I)
        begin
            case (CMD_I)
                CMD_SWITCH_CTRL:
                begin
                    // Only bit 7 kept; host zeros rest
                    switch_nxt = WDATA_I[7:0] & SWITCH_MASK;
                    if (WDATA_I[SWITCH_ON_BIT])
                        pwr_nxt = HSPCB_ON_S;
                    else
                        pwr_nxt = HSPCB_OFF_S;
                end
                CMD_WRITE_GUARD:
                begin
                    if (guard_legal(WDATA_I[7:0]))
                        guard_nxt = WDATA_I[7:0];
                end
                CMD_DIV_RATIO:   ratio_nxt = WDATA_I & DIV_RATIO_MASK;
                CMD_RISE_THRESH: rise_nxt = WDATA_I & RISE_THRESH_MASK;
                default:         rej_nxt = 1'b0;
            endcase
        end
        else if (SEND_STB_I)
        begin
            case (CMD_I)
                CMD_FAULT_CLEAR:  evt_nxt.clear_status = 1'b1;
                CMD_LAST_CLEAR:
                begin
                    evt_nxt.clear_last_nvm = 1'b1;
                    evt_nxt.clear_last_reg = EXT_CLR_LAST_I;
                end
                CMD_LAST_RESTORE: evt_nxt.restore_last = 1'b1;
                CMD_POWER_CYCLE:
                begin
                    pwr_nxt = HSPCB_CYC_S;
                    cyc_nxt = OFF_CYCLES[39:0] - 40'h1;
                end
                CMD_STORE_ALL:
                begin
                    evt_nxt.store_all = 1'b1;
                    evt_nxt.store_rec = !EXT_SKIP_REC_I;
                end
                CMD_RESTORE_ALL:
                begin
                    evt_nxt.restore_all = 1'b1;
                    switch_nxt = NVM_SWITCH_CTRL_I & SWITCH_MASK;
                    ratio_nxt  = NVM_DIV_RATIO_I & DIV_RATIO_MASK;
                    rise_nxt   = NVM_RISE_THRESH_I & RISE_THRESH_MASK;
                end
                default:          rej_nxt = 1'b0;
            endcase
        end
        // Fault latches off; beats a same-cycle on write only while the FET is on (pwr_r == HSPCB_ON_S)
        if (FAULT_SHUTDOWN_I && pwr_r == HSPCB_ON_S)
            pwr_nxt = HSPCB_OFF_S;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            switch_r <= RST_SWITCH_CTRL;
            guard_r  <= RST_WRITE_GUARD;
            ratio_r  <= RST_DIV_RATIO;
            rise_r   <= RST_RISE_THRESH;
            pwr_r    <= HSPCB_ON_S;
            cyc_r    <= 40'h0;
            evt_r    <= '0;
            rej_r    <= 1'b0;
        end
        else
        begin
            switch_r <= switch_nxt;
            guard_r  <= guard_nxt;
            ratio_r  <= ratio_nxt;
            rise_r   <= rise_nxt;
            pwr_r    <= pwr_nxt;
            cyc_r    <= cyc_nxt;
            evt_r    <= evt_nxt;
            rej_r    <= rej_nxt;
        end
    end

    logic [15:0] rd_nxt, rd_r;
    logic        hit_nxt, hit_r;
    logic [9:0]  res_nxt, res_r;

    always_comb
    begin
        hit_nxt = 1'b1;
        case (RD_CMD_I)
            CMD_SWITCH_CTRL: rd_nxt = {8'h00, switch_r};
            CMD_WRITE_GUARD: rd_nxt = {8'h00, guard_r};
            CMD_FEATURE:     rd_nxt = {8'h00, FEATURE_VALUE};
            CMD_DIV_RATIO:   rd_nxt = ratio_r;
            CMD_RISE_THRESH: rd_nxt = rise_r;
            default:
            begin
                rd_nxt  = 16'h0000;
                hit_nxt = 1'b0;
            end
        endcase
        if (EFCFG_FINE_I)
            res_nxt = RES_FINE_MV;
        else if (VPROT_HALF_I)
            res_nxt = RES_MID_MV;
        else
            res_nxt = RES_COARSE_MV;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (RESET_I)
        begin
            rd_r  <= 16'h0000;
            hit_r <= 1'b0;
            res_r <= RES_COARSE_MV;
        end
        else
        begin
            rd_r  <= rd_nxt;
            hit_r <= hit_nxt;
            res_r <= res_nxt;
        end
    end

    assign RDATA_O     = rd_r;
    assign RD_HIT_O    = hit_r;
    assign WR_REJECT_O = rej_r;
    assign FET_ON_O    = (pwr_r == HSPCB_ON_S);
    assign EVT_O       = evt_r;
    assign RISE_CODE_O = rise_r[6:0];
    assign RES_MV_O    = res_r;

    a_guard_locked: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && guard_r == GUARD_LOCKED && CMD_I != CMD_WRITE_GUARD) |=> ($stable(ratio_r) && $stable(switch_r) && WR_REJECT_O))
        else $error("locked write changed state");
    a_guard_ctrl: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && (guard_r & GUARD_CTRL_MASK) == GUARD_CTRL && CMD_I == CMD_RISE_THRESH) |=> $stable(rise_r))
        else $error("control-level write leaked");
    a_guard_open: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && guard_r == GUARD_OPEN && CMD_I == CMD_DIV_RATIO) |=> ratio_r == ($past(WDATA_I) & DIV_RATIO_MASK))
        else $error("open write not taken");
    a_guard_keep: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && CMD_I == CMD_WRITE_GUARD && !guard_legal(WDATA_I[7:0])) |=> $stable(guard_r))
        else $error("illegal guard value taken");
    a_switch_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_SWITCH_CTRL && !WDATA_I[7]) |=> !FET_ON_O)
        else $error("switch off ignored");
    a_reenable: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (WR_STB_I && !FAULT_SHUTDOWN_I && allowed(guard_r, CMD_I) && CMD_I == CMD_SWITCH_CTRL && WDATA_I[7])
        |=> FET_ON_O)
        else $error("on write did not re-enable");
    a_cycle_off: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_POWER_CYCLE) |=> !FET_ON_O [*8])
        else $error("power cycle did not hold off");
    a_feature_rd: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (RD_CMD_I == CMD_FEATURE) |=> RDATA_O == 16'h00D0)
        else $error("feature_report value wrong");
    a_store_rec: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        EVT_O.store_rec |-> (EVT_O.store_all && !$past(EXT_SKIP_REC_I)))
        else $error("record stored while excluded");
    a_upper_zero: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (rise_r[15:7] == 9'h000) && (ratio_r[15:11] == 5'h00))
        else $error("reserved bits set");
    a_fault_wins: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (FAULT_SHUTDOWN_I && FET_ON_O) |=> !FET_ON_O)
        else $error("fault did not switch off");
    a_switch_bits: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (switch_r & ~SWITCH_MASK) == 8'h00)
        else $error("switch reserved bits set");
    a_fault_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_FAULT_CLEAR) |=> EVT_O.clear_status)
        else $error("status clear not issued");
    a_last_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_LAST_CLEAR)
        |=> (EVT_O.clear_last_nvm && EVT_O.clear_last_reg == $past(EXT_CLR_LAST_I)))
        else $error("last fault clear wrong");
    a_last_restore: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_LAST_RESTORE) |=> EVT_O.restore_last)
        else $error("last fault restore not issued");
    a_store_all: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_STORE_ALL)
        |=> (EVT_O.store_all && EVT_O.store_rec == !$past(EXT_SKIP_REC_I)))
        else $error("store all wrong");
    a_restore_all: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (SEND_STB_I && !WR_STB_I && allowed(guard_r, CMD_I) && CMD_I == CMD_RESTORE_ALL)
        |=> (EVT_O.restore_all && ratio_r == ($past(NVM_DIV_RATIO_I) & DIV_RATIO_MASK)))
        else $error("restore all wrong");
    a_send_reject: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        ((WR_STB_I || SEND_STB_I) && !allowed(guard_r, CMD_I))
        |=> (WR_REJECT_O && EVT_O == 7'h00 && $stable(guard_r)))
        else $error("rejected request had effect");
    a_res_fine: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        EFCFG_FINE_I |=> (RES_MV_O == RES_FINE_MV))
        else $error("fine resolution not chosen");
    a_read_guard: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        (RD_CMD_I == CMD_WRITE_GUARD) |=> (RD_HIT_O && RDATA_O == {8'h00, $past(guard_r)}))
        else $error("guard read wrong");
endmodule : hspcb_bank

// ---- hspcb_host.sv ----
module hspcb_host
    import hspcb_pkg::*;
(
    input  wire logic        clk_i,
    output logic             wr_stb_o,
    output logic             send_stb_o,
    output logic [7:0]       cmd_o,
    output logic [15:0]      wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        wr_stb_o   = 1'b0;
        send_stb_o = 1'b0;
        cmd_o      = 8'hFF;
        wdata_o    = 16'h0000;
    end

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk_i);
        wr_stb_o = 1'b1;
        cmd_o    = c;
        wdata_o  = (c == CMD_SWITCH_CTRL) ? (d & {8'h00, SWITCH_MASK}) : d;
        @(negedge clk_i);
        wr_stb_o = 1'b0;
        // Released bus shows inverse, not a stale value
        wdata_o  = ~wdata_o;
    endtask : wr

    task automatic snd(input logic [7:0] c);
        @(negedge clk_i);
        send_stb_o = 1'b1;
        cmd_o      = c;
        @(negedge clk_i);
        send_stb_o = 1'b0;
        cmd_o      = ~c;
    endtask : snd
endmodule : hspcb_host

// ---- hspcb_bank_tb.sv ----
module hspcb_bank_tb
    import hspcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] g; logic [7:0] c; logic [15:0] d; logic [15:0] r; logic rej; logic fet;
    } hspcb_row_s;
    logic clk = 0, rst = 1, wr, sn, flt = 0, ecl = 1, esk = 0, fine = 0, half = 0;
    logic [7:0] cmd, rcmd = 8'h00;
    logic [15:0] wd, rdata;
    logic hit, rej, fet;
    hspcb_evt_s evt, ee;
    logic [6:0] code;
    logic [9:0] res;
    int n_fail = 0, checks = 0, cyc = 0, n;
    hspcb_row_s rows[7] = '{
        '{8'h00, CMD_DIV_RATIO, 16'hFFFF, 16'h07FF, 0, 1},
        '{8'h00, CMD_RISE_THRESH, 16'hFFFF, 16'h007F, 0, 1},
        '{8'h00, CMD_SWITCH_CTRL, 16'h0000, 16'h0000, 0, 0},
        '{8'h40, CMD_SWITCH_CTRL, 16'h0080, 16'h0080, 0, 1},
        '{8'h40, CMD_DIV_RATIO, 16'h0001, 16'h07FF, 1, 1},
        '{8'h60, CMD_RISE_THRESH, 16'h0001, 16'h007F, 1, 1},
        '{8'h80, CMD_SWITCH_CTRL, 16'h0000, 16'h0080, 1, 1}
    };
    logic [7:0] sends[5] = '{CMD_FAULT_CLEAR, CMD_LAST_CLEAR, CMD_LAST_RESTORE, CMD_STORE_ALL, CMD_RESTORE_ALL};

    hspcb_host hspcb_host_i (.clk_i(clk), .wr_stb_o(wr), .send_stb_o(sn), .cmd_o(cmd), .wdata_o(wd));
    hspcb_bank #(.OFF_CYCLES(20)) hspcb_bank_i (
        .CLK_SYS_I(clk), .RESET_I(rst), .WR_STB_I(wr), .SEND_STB_I(sn), .CMD_I(cmd), .WDATA_I(wd),
        .RD_CMD_I(rcmd), .FAULT_SHUTDOWN_I(flt), .EXT_CLR_LAST_I(ecl), .EXT_SKIP_REC_I(esk),
        .EFCFG_FINE_I(fine), .VPROT_HALF_I(half), .NVM_DIV_RATIO_I(16'h0234),
        .NVM_RISE_THRESH_I(16'h0011), .NVM_SWITCH_CTRL_I(8'h80), .RDATA_O(rdata), .RD_HIT_O(hit),
        .WR_REJECT_O(rej), .FET_ON_O(fet), .EVT_O(evt), .RISE_CODE_O(code), .RES_MV_O(res));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string what);
        @(negedge clk);
        rcmd = c;
        @(negedge clk);
        chk(rdata, exp, what);
        chk({15'h0, hit}, 16'h1, "read hit");
    endtask : rd

    task automatic results();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        repeat (8) @(negedge clk);
        rst = 0;
        rd(CMD_SWITCH_CTRL, 16'h0080, "reset switch");
        rd(CMD_WRITE_GUARD, 16'h0000, "reset guard");
        rd(CMD_DIV_RATIO, 16'h0140, "reset ratio");
        rd(CMD_RISE_THRESH, 16'h0023, "reset thresh");
        chk({15'h0, fet}, 16'h1, "reset fet");
        chk({6'h0, res}, 16'd500, "reset res");
        @(negedge clk);
        rcmd = 8'h36;
        @(negedge clk);
        chk({15'h0, hit}, 16'h0, "unknown read");
        $display("test reset done");
        foreach (rows[i])
        begin
            hspcb_host_i.wr(CMD_WRITE_GUARD, {8'h00, rows[i].g});
            hspcb_host_i.wr(rows[i].c, rows[i].d);
            chk({15'h0, rej}, {15'h0, rows[i].rej}, "reject");
            chk({15'h0, fet}, {15'h0, rows[i].fet}, "fet");
            rd(rows[i].c, rows[i].r, "row read");
        end
        $display("test rows done");
        rd(CMD_FEATURE, 16'h00D0, "feature");
        hspcb_host_i.wr(CMD_WRITE_GUARD, 16'h0013);
        rd(CMD_WRITE_GUARD, 16'h0080, "bad guard");
        hspcb_host_i.snd(CMD_POWER_CYCLE);
        chk({15'h0, rej}, 16'h1, "locked send");
        chk({15'h0, fet}, 16'h1, "locked cycle");
        hspcb_host_i.wr(CMD_WRITE_GUARD, 16'h0000);
        $display("test guard done");
        for (int k = 0; k < 2; k++)
        begin
            ecl = ~k[0];
            esk = k[0];
            foreach (sends[j])
            begin
                case (sends[j])
                    CMD_FAULT_CLEAR: ee = 7'b1000000;
                    CMD_LAST_CLEAR:  ee = {2'b01, ecl, 4'b0000};
                    CMD_LAST_RESTORE: ee = 7'b0001000;
                    CMD_STORE_ALL:   ee = {5'b00001, ~esk, 1'b0};
                    default:         ee = 7'b0000001;
                endcase
                hspcb_host_i.snd(sends[j]);
                chk({9'h0, evt}, {9'h0, ee}, "event");
            end
        end
        rd(CMD_DIV_RATIO, 16'h0234, "restored ratio");
        rd(CMD_RISE_THRESH, 16'h0011, "restored thresh");
        chk({9'h0, code}, 16'h0011, "rise code");
        $display("test events done");
        hspcb_host_i.snd(CMD_POWER_CYCLE);
        n = 0;
        while (fet === 1'b0 && n < 100)
        begin
            n++;
            @(negedge clk);
        end
        chk(n[15:0], 16'd20, "cycle off time");
        @(negedge clk);
        flt = 1;
        @(negedge clk);
        flt = 0;
        chk({15'h0, fet}, 16'h0, "fault off");
        hspcb_host_i.wr(CMD_SWITCH_CTRL, 16'h0080);
        chk({15'h0, fet}, 16'h1, "re-enable");
        // Fault in the same cycle as an on write must win while the FET is on
        fork
            hspcb_host_i.wr(CMD_SWITCH_CTRL, 16'h0080);
            begin
                @(negedge clk);
                flt = 1;
                @(negedge clk);
                flt = 0;
            end
        join
        chk({15'h0, fet}, 16'h0, "fault beats on write");
        hspcb_host_i.wr(CMD_SWITCH_CTRL, 16'h0080);
        chk({15'h0, fet}, 16'h1, "re-enable again");
        $display("test power done");
        for (int k = 0; k < 4; k++)
        begin
            fine = k[1];
            half = k[0];
            repeat (2) @(negedge clk);
            chk({6'h0, res}, k[1] ? 16'd125 : (k[0] ? 16'd250 : 16'd500), "resolution");
        end
        $display("test resolution done");
        results();
    end
endmodule : hspcb_bank_tb
